// ---- cpu_special_register_core.v ----
`timescale 1ns/100ps
`include "cpu_special_register_map.vh"

module cpu_special_register_core (
  input  wire        clk,              // System clock, 50 MHz.
  input  wire        resetn,           // Synchronous power-up reset, active low.
  input  wire        mem_req,          // One-cycle data memory access request.
  input  wire        mem_write,        // High for a write, low for a read.
  input  wire [11:0] mem_addr,         // Sector in bits 11:8, location in bits 7:0.
  input  wire [7:0]  mem_wdata,        // Write data.
  output reg  [7:0]  mem_rdata,        // Read data, valid with mem_rdata_valid.
  output reg         mem_rdata_valid,  // One-cycle pulse after a read request.
  input  wire        alu_go,           // One-cycle pulse: execute an ALU operation.
  input  wire [3:0]  alu_op,           // ALU operation code.
  input  wire [7:0]  alu_operand,      // Second operand, the accumulator is the first.
  output reg  [7:0]  accumulator,      // Accumulator contents.
  output reg  [7:0]  status,           // Status register contents.
  input  wire        clear_watchdog_instruction, // Pulse: clear-watchdog executed.
  input  wire        halt_instruction, // Pulse: halt executed.
  input  wire        watchdog_timeout, // Pulse: the watchdog timed out.
  input  wire        jump_go,          // Pulse: jump or call taken.
  input  wire [12:0] jump_target,      // Destination inside the selected bank.
  input  wire        pc_step,          // Pulse: advance to the next instruction.
  output reg  [13:0] program_counter,  // Program counter, bit 13 is the bank.
  output reg         dummy_cycle,      // One-cycle pulse: insert a dummy cycle.
  output reg         bank_select_bit,  // Current program bank selection.
  input  wire        table_read_go,    // Pulse: start a table read.
  output reg  [13:0] table_fetch_addr, // Program memory address of the table word.
  output reg         table_fetch_req,  // One-cycle program memory read strobe.
  input  wire [15:0] table_fetch_word, // Program memory word, the cycle after strobe.
  output reg  [7:0]  table_low_data,   // Low table byte for the named destination.
  output reg         table_low_valid   // One-cycle pulse with the low table byte.
);

  // General purpose memory: sixteen sectors of 128 bytes.
  reg [7:0]  data_memory [0:2047];

  // Physical pointer and table registers.
  reg [7:0]  sector0_pointer_reg;      // Pointer used by indirect port zero.
  reg [7:0]  pointer_one_low_reg;      // Location used by indirect port one.
  reg [7:0]  pointer_one_sector_reg;   // Sector used by indirect port one.
  reg [7:0]  pointer_two_low_reg;      // Location used by indirect port two.
  reg [7:0]  pointer_two_sector_reg;   // Sector used by indirect port two.
  reg [7:0]  table_pointer_low_reg;    // Table pointer low byte.
  reg [7:0]  table_pointer_high_reg;   // Table pointer high byte.
  reg [7:0]  table_result_high_reg;    // High byte of the last table word.

  // Address resolution results.
  reg [11:0] target_addr;              // Address after indirect redirection.
  reg        via_port;                 // The request went through a port.
  reg        target_is_port;           // The final target is itself a port.
  reg        target_in_ram;            // The final target is general memory.
  reg        target_is_sfr;            // The final target is a sector 0 register.
  wire [10:0] ram_index;               // Index into the general purpose array.

  // ALU intermediate values.
  reg [7:0]  alu_b;                    // Operand after inversion for subtraction.
  reg        alu_cin;                  // Carry into bit 0.
  reg [8:0]  alu_sum;                  // Full sum with carry out.
  reg [4:0]  alu_nibble;               // Low nibble sum with its carry.
  reg [7:0]  alu_low7;                 // Sum of the low seven bits.
  reg        alu_arith;                // Operation is an addition or subtraction.
  reg [7:0]  alu_result;               // Result written to the accumulator.
  reg [7:0]  status_next;              // Status value after this cycle.
  reg        table_pending_reg;        // Table word arrives in this cycle.
  reg [7:0]  sfr_rdata;                // Read value of the addressed register.

  // Redirect indirect port accesses to the address held by their pointers.
  always @* begin
    via_port    = 1'b0;
    target_addr = mem_addr;
    if (mem_addr[11:8] == 4'h0) begin
      case (mem_addr[7:0])
        `OFS_INDIRECT_PORT_ZERO: begin
          via_port    = 1'b1;
          target_addr = {4'h0, sector0_pointer_reg};
        end
        `OFS_INDIRECT_PORT_ONE: begin
          via_port    = 1'b1;
          target_addr = {pointer_one_sector_reg[3:0], pointer_one_low_reg};
        end
        `OFS_INDIRECT_PORT_TWO: begin
          via_port    = 1'b1;
          target_addr = {pointer_two_sector_reg[3:0], pointer_two_low_reg};
        end
        default: begin
          via_port    = 1'b0;
          target_addr = mem_addr;
        end
      endcase
    end
  end

  // Classify the final target; a port reached through a port is a void location.
  always @* begin
    target_is_port = via_port && (target_addr[11:8] == 4'h0) &&
                     ((target_addr[7:0] == `OFS_INDIRECT_PORT_ZERO) ||
                      (target_addr[7:0] == `OFS_INDIRECT_PORT_ONE) ||
                      (target_addr[7:0] == `OFS_INDIRECT_PORT_TWO));
    target_in_ram  = (target_addr[7:0] >= `GP_FIRST_OFFSET);
    target_is_sfr  = !target_in_ram && (target_addr[11:8] == 4'h0) && !target_is_port;
  end

  assign ram_index = {target_addr[11:8], target_addr[6:0]};

  // Read multiplexer of the sector 0 registers; unused locations read zero.
  always @* begin
    case (target_addr[7:0])
      `OFS_SECTOR0_POINTER:     sfr_rdata = sector0_pointer_reg;
      `OFS_POINTER_ONE_LOW:     sfr_rdata = pointer_one_low_reg;
      `OFS_POINTER_ONE_SECTOR:  sfr_rdata = pointer_one_sector_reg;
      `OFS_ACCUMULATOR:         sfr_rdata = accumulator;
      `OFS_PROGRAM_COUNTER_LOW: sfr_rdata = program_counter[7:0];
      `OFS_TABLE_POINTER_LOW:   sfr_rdata = table_pointer_low_reg;
      `OFS_TABLE_RESULT_HIGH:   sfr_rdata = table_result_high_reg;
      `OFS_TABLE_POINTER_HIGH:  sfr_rdata = table_pointer_high_reg;
      `OFS_STATUS:              sfr_rdata = status;
      `OFS_PROGRAM_BANK_SELECT: sfr_rdata = {7'h00, bank_select_bit};
      `OFS_POINTER_TWO_LOW:     sfr_rdata = pointer_two_low_reg;
      `OFS_POINTER_TWO_SECTOR:  sfr_rdata = pointer_two_sector_reg;
      default:                  sfr_rdata = `READ_OF_NOTHING;
    endcase
  end

  // Combinational ALU working on the accumulator and the operand.
  always @* begin
    alu_arith  = (alu_op == `ALU_ADD) || (alu_op == `ALU_ADC) ||
                 (alu_op == `ALU_SUB) || (alu_op == `ALU_SBC);
    // Subtraction adds the inverted operand; a carry out means no borrow.
    alu_b      = alu_op[1] ? ~alu_operand : alu_operand;
    case (alu_op)
      `ALU_SUB: alu_cin = 1'b1;
      `ALU_ADC: alu_cin = status[`ST_CARRY];
      `ALU_SBC: alu_cin = status[`ST_CARRY];
      default:  alu_cin = 1'b0;
    endcase
    alu_sum    = {1'b0, accumulator} + {1'b0, alu_b} + {8'h00, alu_cin};
    alu_nibble = {1'b0, accumulator[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
    alu_low7   = {1'b0, accumulator[6:0]} + {1'b0, alu_b[6:0]} + {7'h00, alu_cin};
    case (alu_op)
      `ALU_AND: alu_result = accumulator & alu_operand;
      `ALU_OR:  alu_result = accumulator | alu_operand;
      `ALU_XOR: alu_result = accumulator ^ alu_operand;
      `ALU_RRC: alu_result = {status[`ST_CARRY], accumulator[7:1]};
      `ALU_RLC: alu_result = {accumulator[6:0], status[`ST_CARRY]};
      default:  alu_result = alu_sum[7:0];
    endcase
  end

  // Next status value: software write, ALU flags, then the system events.
  always @* begin
    status_next = status;
    if (mem_req && mem_write && target_is_sfr &&
        (target_addr[7:0] == `OFS_STATUS)) begin
      status_next = (mem_wdata & `STATUS_WRITE_MASK) | (status & ~`STATUS_WRITE_MASK);
    end
    if (alu_go) begin
      if (alu_arith) begin
        status_next[`ST_CARRY]          = alu_sum[8];
        status_next[`ST_AUX_CARRY]      = alu_nibble[4];
        status_next[`ST_OVERFLOW]       = alu_low7[7] ^ alu_sum[8];
        status_next[`ST_SIGNED_COMPARE] = (alu_low7[7] ^ alu_sum[8]) ^ alu_sum[7];
      end
      if (alu_op == `ALU_RRC) begin
        status_next[`ST_CARRY] = accumulator[0];
      end else if (alu_op == `ALU_RLC) begin
        status_next[`ST_CARRY] = accumulator[7];
      end else begin
        status_next[`ST_ZERO] = (alu_result == 8'h00);
      end
      if (alu_op == `ALU_SUB) begin
        status_next[`ST_COMPARE_ZERO] = (alu_result == 8'h00);
      end else if (alu_op == `ALU_SBC) begin
        status_next[`ST_COMPARE_ZERO] = status[`ST_COMPARE_ZERO] && (alu_result == 8'h00);
      end
    end
    if (clear_watchdog_instruction) begin
      status_next[`ST_POWER_DOWN] = 1'b0;
    end else if (halt_instruction) begin
      status_next[`ST_POWER_DOWN] = 1'b1;
    end
    if (watchdog_timeout) begin
      status_next[`ST_WDT_TIMEOUT] = 1'b1;
    end else if (clear_watchdog_instruction || halt_instruction) begin
      status_next[`ST_WDT_TIMEOUT] = 1'b0;
    end
  end

  // General purpose memory port; no reset, contents start unknown.
  always @(posedge clk) begin
    if (mem_req && mem_write && target_in_ram && !target_is_port) begin
      data_memory[ram_index] <= mem_wdata;
    end
  end

  // Read data path, registered one cycle after the request.
  always @(posedge clk) begin
    if (!resetn) begin
      mem_rdata       <= 8'h00;
      mem_rdata_valid <= 1'b0;
    end else begin
      mem_rdata_valid <= mem_req && !mem_write;
      if (mem_req && !mem_write) begin
        if (target_is_port) begin
          mem_rdata <= `READ_OF_NOTHING;
        end else if (target_in_ram) begin
          mem_rdata <= data_memory[ram_index];
        end else if (target_is_sfr) begin
          mem_rdata <= sfr_rdata;
        end else begin
          mem_rdata <= `READ_OF_NOTHING;
        end
      end
    end
  end

  // Sector 0 register writes, ALU results and status.
  always @(posedge clk) begin
    if (!resetn) begin
      sector0_pointer_reg    <= 8'h00;
      pointer_one_low_reg    <= 8'h00;
      pointer_one_sector_reg <= 8'h00;
      pointer_two_low_reg    <= 8'h00;
      pointer_two_sector_reg <= 8'h00;
      table_pointer_low_reg  <= 8'h00;
      table_pointer_high_reg <= 8'h00;
      accumulator            <= 8'h00;
      status                 <= `STATUS_RESET;
      bank_select_bit        <= `BANK_SELECT_BIT_RESET;
    end else begin
      status <= status_next;
      if (alu_go) begin
        accumulator <= alu_result;
      end else if (mem_req && mem_write && target_is_sfr &&
                   (target_addr[7:0] == `OFS_ACCUMULATOR)) begin
        accumulator <= mem_wdata;
      end
      if (mem_req && mem_write && target_is_sfr) begin
        case (target_addr[7:0])
          `OFS_SECTOR0_POINTER:     sector0_pointer_reg    <= mem_wdata;
          `OFS_POINTER_ONE_LOW:     pointer_one_low_reg    <= mem_wdata;
          `OFS_POINTER_ONE_SECTOR:  pointer_one_sector_reg <= mem_wdata;
          `OFS_POINTER_TWO_LOW:     pointer_two_low_reg    <= mem_wdata;
          `OFS_POINTER_TWO_SECTOR:  pointer_two_sector_reg <= mem_wdata;
          `OFS_TABLE_POINTER_LOW:   table_pointer_low_reg  <= mem_wdata;
          `OFS_TABLE_POINTER_HIGH:  table_pointer_high_reg <= mem_wdata;
          `OFS_PROGRAM_BANK_SELECT: bank_select_bit        <= mem_wdata[0];
          default: begin
          end
        endcase
      end
    end
  end

  // Program counter: low byte writes, bank jumps and plain steps.
  always @(posedge clk) begin
    if (!resetn) begin
      program_counter <= 14'h0000;
      dummy_cycle     <= 1'b0;
    end else begin
      dummy_cycle <= 1'b0;
      if (mem_req && mem_write && target_is_sfr &&
          (target_addr[7:0] == `OFS_PROGRAM_COUNTER_LOW)) begin
        program_counter <= {program_counter[13:8], mem_wdata};
        dummy_cycle     <= 1'b1;
      end else if (jump_go) begin
        program_counter <= {bank_select_bit, jump_target};
      end else if (pc_step) begin
        program_counter <= program_counter + 14'h0001;
      end
    end
  end

  // Table read: strobe the word address, then split the returned word.
  always @(posedge clk) begin
    if (!resetn) begin
      table_fetch_addr      <= 14'h0000;
      table_fetch_req       <= 1'b0;
      table_pending_reg     <= 1'b0;
      table_low_data        <= 8'h00;
      table_low_valid       <= 1'b0;
      table_result_high_reg <= 8'h00;
    end else begin
      table_fetch_req   <= table_read_go;
      table_pending_reg <= table_fetch_req;
      table_low_valid   <= 1'b0;
      if (table_read_go) begin
        table_fetch_addr <= {table_pointer_high_reg[5:0], table_pointer_low_reg};
      end
      if (table_pending_reg) begin
        table_result_high_reg <= table_fetch_word[15:8];
        table_low_data        <= table_fetch_word[7:0];
        table_low_valid       <= 1'b1;
      end
    end
  end

endmodule // cpu_special_register_core

// ---- cpu_special_register_map.vh ----
`ifndef CPU_SPECIAL_REGISTER_MAP_VH
`define CPU_SPECIAL_REGISTER_MAP_VH
// Sector 0 special register offsets (low byte of the data address).
`define OFS_INDIRECT_PORT_ZERO    8'h00
`define OFS_SECTOR0_POINTER       8'h01
`define OFS_INDIRECT_PORT_ONE     8'h02
`define OFS_POINTER_ONE_LOW       8'h03
`define OFS_POINTER_ONE_SECTOR    8'h04
`define OFS_ACCUMULATOR           8'h05
`define OFS_PROGRAM_COUNTER_LOW   8'h06
`define OFS_TABLE_POINTER_LOW     8'h07
`define OFS_TABLE_RESULT_HIGH     8'h08
`define OFS_TABLE_POINTER_HIGH    8'h09
`define OFS_STATUS                8'h0a
`define OFS_PROGRAM_BANK_SELECT   8'h0b
`define OFS_INDIRECT_PORT_TWO     8'h0c
`define OFS_POINTER_TWO_LOW       8'h0d
`define OFS_POINTER_TWO_SECTOR    8'h0e
// First general purpose location inside each sector.
`define GP_FIRST_OFFSET           8'h80
// Status field positions.
`define ST_CARRY                  0
`define ST_AUX_CARRY              1
`define ST_ZERO                   2
`define ST_OVERFLOW               3
`define ST_POWER_DOWN             4
`define ST_WDT_TIMEOUT            5
`define ST_COMPARE_ZERO           6
`define ST_SIGNED_COMPARE         7
// Status bits that software writes may change.
`define STATUS_WRITE_MASK         8'hcf
// Reset values.
`define STATUS_RESET              8'h00
`define PROGRAM_BANK_RESET        8'h00
`define BANK_SELECT_BIT_RESET     1'b0
`define READ_OF_NOTHING           8'h00
// ALU operation codes.
`define ALU_ADD                   4'h0
`define ALU_ADC                   4'h1
`define ALU_SUB                   4'h2
`define ALU_SBC                   4'h3
`define ALU_AND                   4'h4
`define ALU_OR                    4'h5
`define ALU_XOR                   4'h6
`define ALU_RRC                   4'h7
`define ALU_RLC                   4'h8
`endif

// ---- cpu_special_register_core_properties.sv ----
`timescale 1ns/100ps
`include "cpu_special_register_map.vh"
// Watches the core's ports and checks timing relations between them.
module cpu_special_register_core_properties (
  input wire        clk,
  input wire        resetn,
  input wire        mem_req,
  input wire        mem_write,
  input wire [11:0] mem_addr,
  input wire [7:0]  mem_wdata,
  input wire [7:0]  mem_rdata,
  input wire        mem_rdata_valid,
  input wire        alu_go,
  input wire [3:0]  alu_op,
  input wire [7:0]  accumulator,
  input wire [7:0]  status,
  input wire        clear_watchdog_instruction,
  input wire        halt_instruction,
  input wire        watchdog_timeout,
  input wire        jump_go,
  input wire [12:0] jump_target,
  input wire [13:0] program_counter,
  input wire        dummy_cycle,
  input wire        bank_select_bit,
  input wire        table_read_go,
  input wire        table_fetch_req,
  input wire        table_low_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // High when the low program counter byte is written.
  wire pcl_wr = mem_req && mem_write && mem_addr == 12'h006;
  // High when the status register is written with no flag event pending.
  wire st_wr  = mem_req && mem_write && mem_addr == 12'h00a && !halt_instruction
                && !clear_watchdog_instruction && !watchdog_timeout;
  // The dummy cycle ends unless another low byte write follows at once.
  sequence s_dummy;
    dummy_cycle ##1 (!dummy_cycle || $past(pcl_wr));
  endsequence
  // The fetch strobe comes first, the low byte two cycles later.
  sequence s_fetch;
    table_fetch_req ##2 table_low_valid;
  endsequence
  a_read_answer: assert property (mem_req && !mem_write |=> mem_rdata_valid)
    else $error("read got no answer");
  a_bank_upper_zero: assert property (mem_req && !mem_write && mem_addr == 12'h00b
    |=> mem_rdata[7:1] == 7'h00) else $error("bank register upper bits not zero");
  a_jump_bank: assert property (jump_go && !pcl_wr
    |=> program_counter == {$past(bank_select_bit), $past(jump_target)})
    else $error("jump landed outside selected bank");
  a_pcl_jump: assert property (pcl_wr |=> program_counter[7:0] == $past(mem_wdata)
    && program_counter[13:8] == $past(program_counter[13:8]) ##0 s_dummy)
    else $error("low byte jump wrong");
  a_status_protect: assert property (st_wr |=> status[5:4] == $past(status[5:4]))
    else $error("status write changed protected flags");
  a_timeout_set: assert property (watchdog_timeout |=> status[5])
    else $error("timeout flag not set");
  a_zero_flag: assert property (alu_go && alu_op inside {`ALU_AND, `ALU_OR, `ALU_XOR}
    |=> status[2] == (accumulator == 8'h00)) else $error("zero flag wrong");
  a_table_order: assert property (table_read_go |=> s_fetch)
    else $error("table read sequence wrong");
endmodule // cpu_special_register_core_properties

bind cpu_special_register_core cpu_special_register_core_properties u_props (
  .clk(clk), .resetn(resetn), .mem_req(mem_req), .mem_write(mem_write),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .mem_rdata_valid(mem_rdata_valid), .alu_go(alu_go), .alu_op(alu_op),
  .accumulator(accumulator), .status(status),
  .clear_watchdog_instruction(clear_watchdog_instruction),
  .halt_instruction(halt_instruction), .watchdog_timeout(watchdog_timeout),
  .jump_go(jump_go), .jump_target(jump_target), .program_counter(program_counter),
  .dummy_cycle(dummy_cycle), .bank_select_bit(bank_select_bit),
  .table_read_go(table_read_go), .table_fetch_req(table_fetch_req),
  .table_low_valid(table_low_valid));

// ---- program_memory_model.sv ----
`timescale 1ns/100ps
// Program memory seen by the table read logic.
module program_memory_model (
  input  wire         clk,
  input  wire         table_fetch_req,
  input  wire [13:0]  table_fetch_addr,
  output wire  [15:0] table_fetch_word
);
  logic [1:0]  hold = 2'h0;         // Cycles the fetched word still stands.
  logic [15:0] word_reg = 16'h0000; // Word shown to the table read logic.
  assign table_fetch_word = word_reg;
  // supplies the table word
  // The strobe is sampled at the edge, so the word stands for the next edge.
  // Outside the hold window the word toggles, so a late sample is caught.
  always @(posedge clk) begin
    if (table_fetch_req) begin
      hold <= 2'h2;
      word_reg <= {2'b00, table_fetch_addr} ^ 16'ha5c3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      word_reg <= ~word_reg;
    end
  end
endmodule // program_memory_model

// ---- testbench.sv ----
`timescale 1ns/100ps
`include "cpu_special_register_map.vh"
// Self-checking bench for the special register core.
module testbench;
  logic        clk, resetn, mem_req, mem_write, alu_go, jump_go, pc_step, tbl_go;
  logic        clr_wd, halt_i, wd_to, rd_valid, dummy, bank, fetch_req, low_valid;
  logic [11:0] mem_addr;
  logic [7:0]  wdata, rdata, operand, acc, status, low_data, st_m, d, th, tl;
  logic [3:0]  op;
  logic [12:0] target;
  logic [13:0] pc, fetch_addr;
  logic [15:0] fetch_word, r;
  logic [7:0]  rd_q[$], low_q[$];
  logic [2:0]  ev[6] = '{3'b010, 3'b001, 3'b010, 3'b100, 3'b010, 3'b001};
  int          mismatches, total_checks, cycles, i;

  cpu_special_register_core dut (.clk(clk), .resetn(resetn), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(wdata), .mem_rdata(rdata),
    .mem_rdata_valid(rd_valid), .alu_go(alu_go), .alu_op(op), .alu_operand(operand),
    .accumulator(acc), .status(status), .clear_watchdog_instruction(clr_wd),
    .halt_instruction(halt_i), .watchdog_timeout(wd_to), .jump_go(jump_go),
    .jump_target(target), .pc_step(pc_step), .program_counter(pc), .dummy_cycle(dummy),
    .bank_select_bit(bank), .table_read_go(tbl_go), .table_fetch_addr(fetch_addr),
    .table_fetch_req(fetch_req), .table_fetch_word(fetch_word),
    .table_low_data(low_data), .table_low_valid(low_valid));
  program_memory_model pmem (.clk(clk), .table_fetch_req(fetch_req),
    .table_fetch_addr(fetch_addr), .table_fetch_word(fetch_word));

  // Free running 50 MHz clock.
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task tick;
    @(posedge clk);
    #1;
  endtask
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A write takes one cycle, then an idle cycle follows.
  task wr(input logic [11:0] a, input logic [7:0] v);
    mem_req = 1; mem_write = 1; mem_addr = a; wdata = v;
    tick;
    mem_req = 0;
    tick;
  endtask
  // A read notes its expected data for the monitor.
  task rd(input logic [11:0] a, input logic [7:0] v);
    mem_req = 1; mem_write = 0; mem_addr = a; rd_q.push_back(v);
    tick;
    mem_req = 0;
    tick;
  endtask
  // Reference ALU: returns the accumulator and status after one operation.
  function automatic logic [15:0] alu_ref(input logic [3:0] o, input logic [7:0] a, b, s);
    logic [7:0] x, rs, l;
    logic [8:0] t;
    logic [4:0] n;
    logic       ci;
    x = o[1] ? ~b : b;
    ci = (o == `ALU_ADD) ? 1'b0 : (o == `ALU_SUB) ? 1'b1 : s[0];
    t = a + x + ci;
    n = a[3:0] + x[3:0] + ci;
    l = a[6:0] + x[6:0] + ci;
    rs = t[7:0];
    if (o <= `ALU_SBC) begin
      s[0] = t[8]; s[1] = n[4]; s[3] = l[7] ^ t[8]; s[2] = (rs == 8'h00); s[7] = s[3] ^ rs[7];
      if (o == `ALU_SUB) s[6] = s[2];
      if (o == `ALU_SBC) s[6] = s[6] & s[2];
    end else if (o == `ALU_RRC) begin
      rs = {s[0], a[7:1]}; s[0] = a[0];
    end else if (o == `ALU_RLC) begin
      rs = {a[6:0], s[0]}; s[0] = a[7];
    end else begin
      rs = (o == `ALU_AND) ? a & b : (o == `ALU_OR) ? a | b : a ^ b;
      s[2] = (rs == 8'h00);
    end
    return {rs, s};
  endfunction

  // Monitor: compares each answer with the oldest note, and cuts a hang.
  always @(posedge clk) begin
    if (resetn && rd_valid)
      check("read data", rdata, rd_q.size() ? rd_q.pop_front() : 8'hxx);
    if (resetn && low_valid)
      check("table low", low_data, low_q.size() ? low_q.pop_front() : 8'hxx);
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test;
    end
  end

  initial begin
    {mem_req, mem_write, alu_go, jump_go, pc_step, tbl_go, clr_wd, halt_i, wd_to} = 0;
    mem_addr = 0; wdata = 0; operand = 0; op = 0; target = 0; resetn = 0;
    mismatches = 0; total_checks = 0; cycles = 0; st_m = 0;
    void'($urandom(6728));
    repeat (16) @(posedge clk);
    #1 resetn = 1;
    check("status reset", status, 8'h00);
    check("bank reset", bank, 1'b0);
    // Indirect ports, pointers and extended addressing.
    d = 8'($urandom);
    wr(12'h001, 8'h85); rd(12'h001, 8'h85);
    wr(12'h000, d); rd(12'h085, d);
    wr(12'h004, 8'h03); wr(12'h003, 8'h90); wr(12'h002, ~d); rd(12'h390, ~d);
    rd(12'h004, 8'h03);
    wr(12'h00e, 8'h0f); wr(12'h00d, 8'hff); wr(12'h00c, d ^ 8'h3c); rd(12'hfff, d ^ 8'h3c);
    rd(12'h00c, d ^ 8'h3c);
    wr(12'h001, 8'h02); rd(12'h000, 8'h00);
    wr(12'h000, d); rd(12'h390, ~d);
    wr(12'h010, 8'hff); rd(12'h010, 8'h00);
    // Halt, timeout and clear events on the protected flags.
    for (i = 0; i < 6; i++) begin
      {clr_wd, halt_i, wd_to} = ev[i];
      tick;
      {clr_wd, halt_i, wd_to} = 0;
      if (ev[i][2]) st_m[5:4] = 2'b00;
      if (ev[i][1]) st_m[5:4] = {1'b0, ~ev[i][2]};
      if (ev[i][0]) st_m[5] = 1'b1;
      check("event flags", status, st_m);
      tick;
    end
    // Status writes and every ALU operation with random operands.
    for (i = 0; i < 18; i++) begin
      d = 8'($urandom);
      wr(12'h00a, d);
      st_m = (st_m & ~`STATUS_WRITE_MASK) | (d & `STATUS_WRITE_MASK);
      check("status write", status, st_m);
      d = 8'($urandom);
      wr(12'h005, d);
      alu_go = 1; op = 4'(i % 9); operand = 8'($urandom);
      tick;
      alu_go = 0;
      r = alu_ref(op, d, operand, st_m);
      st_m = r[7:0];
      check("accumulator", acc, r[15:8]);
      check("alu flags", status, st_m);
      tick;
    end
    // Bank selection and jumps into both banks.
    for (i = 0; i < 2; i++) begin
      wr(12'h00b, {7'h55, i[0]}); rd(12'h00b, {7'h00, i[0]});
      check("bank bit", bank, i[0]);
      jump_go = 1; target = 13'($urandom);
      tick;
      jump_go = 0;
      check("jump target", pc, {i[0], target});
      tick;
    end
    // Writing the low program counter byte.
    d = 8'($urandom);
    mem_req = 1; mem_write = 1; mem_addr = 12'h006; wdata = d;
    tick;
    mem_req = 0;
    check("low byte jump", pc, {1'b1, target[12:8], d});
    check("dummy cycle", dummy, 1'b1);
    tick;
    check("dummy ends", dummy, 1'b0);
    pc_step = 1;
    tick;
    pc_step = 0;
    check("pc step", pc, {1'b1, target[12:8], d} + 14'h0001);
    // Table read through the partner memory.
    tl = 8'($urandom); th = 8'($urandom);
    wr(12'h007, tl); wr(12'h009, th);
    tbl_go = 1;
    tick;
    tbl_go = 0;
    check("fetch", {fetch_req, 1'b0, fetch_addr}, {2'b10, th[5:0], tl});
    low_q.push_back(tl ^ 8'hc3);
    repeat (3) tick;
    rd(12'h008, {2'b00, th[5:0]} ^ 8'ha5);
    repeat (4) tick;
    check("notes left", rd_q.size() + low_q.size(), 16'h0000);
    stop_test;
  end
endmodule // testbench
